// [hdl/rsdcfg_consts.svh]
// Constants for the RS485 drive slave configuration block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef RSDCFG_CONSTS_SVH
`define RSDCFG_CONSTS_SVH

// Register word offsets (address port is a word index).
`define RSDCFG_A_PROTOCOL      4'h0
`define RSDCFG_A_BAUD          4'h1
`define RSDCFG_A_CFG_ADDR      4'h2
`define RSDCFG_A_PD_WORDS      4'h3
`define RSDCFG_A_PC_WORDS      4'h4
`define RSDCFG_A_PRESET        4'h5
`define RSDCFG_A_MON_PERIOD    4'h6
`define RSDCFG_A_STATUS        4'h7
`define RSDCFG_A_IRQ_STATUS    4'h8
`define RSDCFG_A_IRQ_ENABLE    4'h9
`define RSDCFG_A_IRQ_CLEAR     4'ha
`define RSDCFG_A_ACTIVE_ADDR   4'hb

// Reset values and encodings.
`define RSDCFG_PROTOCOL_ON     8'h01
`define RSDCFG_BAUD_RST        4'h8
`define RSDCFG_BAUD_MAX        4'hb
`define RSDCFG_ADDR_RST        5'h00
`define RSDCFG_ADDR_MAX        6'h1f
`define RSDCFG_PD_RST          4'h2
`define RSDCFG_PD_MAX          4'h8
`define RSDCFG_PC_RST          7'h04
`define RSDCFG_PC_VAR          7'h7f
`define RSDCFG_PRESET_BUS      8'h15
`define RSDCFG_MON_RST_MS      21'h000064
`define RSDCFG_CLK_HZ          250000000
`define RSDCFG_MS_PER_S        1000
`define RSDCFG_SYNC_FILL       2'h3

// Interrupt bit positions.
`define RSDCFG_IRQ_TIMEOUT     0
`define RSDCFG_IRQ_FRAME       1
`define RSDCFG_IRQ_REJECT      2
`define RSDCFG_IRQ_W           3

`endif

// [hdl/rsdcfg_pkg.sv]
// Types shared by the RS485 drive slave configuration block.
// Assumes the constants header is on the include path.
`include "rsdcfg_consts.svh"

package rsdcfg_pkg;
  typedef logic [3:0]  rsdcfg_addr_type;
  typedef logic [31:0] rsdcfg_data_type;
  typedef enum logic [1:0]
  {
    RSDCFG_IDLE,
    RSDCFG_ANSWER,
    RSDCFG_FAULT
  } rsdcfg_state_type;
endpackage

// [hdl/rsdcfg_top.sv]
// RS485 drive slave configuration: setup registers, latched bus address,
// bus monitoring and transmitter gating.
// Assumes a register master on clk and framing logic that reports
// received master telegrams and the end of each answer.
//
// Function
// - The device only ever answers the single master and never starts a transfer itself.
// - Only station addresses 0 through 31 count as valid.
// - A valid selector switch address overrides the software address.
// - The software address resets to 0 and takes writes only while the switch is invalid.
// - The address in use is latched once after power-up and never changes in operation.
// - Protocol select equal to 1 enables the serial drive protocol.
// - Baud select resets to code 8 (38400 bit/s); codes span 2400 to 187500 bit/s.
// - Process-data word count spans 0 to 8 sixteen-bit words, default 2.
// - Setup preset 21 enables command and setpoint exchange over the bus.
// - Missing process data for one monitor period faults and stops; period 0 disables it.
// - Parameter-channel length is 0, 3 or 4 words or variable with code 127.
`timescale 1ns/1ps
`include "rsdcfg_consts.svh"

module rsdcfg_top
#(
  parameter int unsigned MON_MS_DEFAULT = `RSDCFG_MON_RST_MS,
  parameter int unsigned CYCLES_PER_MS  = `RSDCFG_CLK_HZ / `RSDCFG_MS_PER_S
)
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  input  wire rsdcfg_pkg::rsdcfg_addr_type reg_addr,
  input  wire rsdcfg_pkg::rsdcfg_data_type reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic [31:0]                    reg_rdata,
  input  wire logic [5:0]                addr_switch,
  input  wire logic                      frame_valid,
  input  wire logic [4:0]                frame_addr,
  input  wire logic                      frame_has_pd,
  input  wire logic                      answer_done,
  output logic                           bus_enable,
  output logic                           tx_enable,
  output logic [4:0]                     station_addr,
  output logic                           drive_fault,
  output logic                           irq
);
  import rsdcfg_pkg::*;

  initial
  begin
    if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 21'h1fffff ||
        MON_MS_DEFAULT > 21'h1fffff)
      $error("rsdcfg_top: unsupported parameter values");
  end

  // ==========================================================================
  // Reset release and switch synchroniser
  // ==========================================================================
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  logic [5:0] sw_s1_q;
  logic [5:0] sw_s2_q;
  logic [5:0] sw_s3_q;
  logic [5:0] sw_q;
  logic [1:0] fill_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_s1_q <= 6'h3f;
      sw_s2_q <= 6'h3f;
      sw_s3_q <= 6'h3f;
      sw_q    <= 6'h3f;
      fill_q  <= 2'h0;
    end
    else if (clk_en)
    begin
      sw_s1_q <= addr_switch;
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (fill_q != `RSDCFG_SYNC_FILL)
        fill_q <= fill_q + 2'h1;
      if (sw_s2_q == sw_s3_q)
        sw_q <= sw_s3_q;
    end
  end

  // The address latch waits until all three stages hold pin samples, so the reset
  // value of the filter is never mistaken for a settled switch setting.
  wire sync_full = fill_q == `RSDCFG_SYNC_FILL;
  wire sw_valid  = (sw_q <= `RSDCFG_ADDR_MAX);

  // ==========================================================================
  // Register decode
  // ==========================================================================
  logic [7:0]  protocol_select_q;
  logic [3:0]  baud_rate_select_q;
  logic [4:0]  configured_station_address_q;
  logic [3:0]  process_word_count_q;
  logic [6:0]  param_channel_word_count_q;
  logic [7:0]  setup_preset_select_q;
  logic [20:0] bus_monitor_period_q;
  logic [`RSDCFG_IRQ_W-1:0] irq_status_q;
  logic [`RSDCFG_IRQ_W-1:0] irq_enable_q;

  wire wr_protocol = reg_write && reg_addr == `RSDCFG_A_PROTOCOL;
  wire wr_baud     = reg_write && reg_addr == `RSDCFG_A_BAUD;
  wire wr_addr     = reg_write && reg_addr == `RSDCFG_A_CFG_ADDR;
  wire wr_pd       = reg_write && reg_addr == `RSDCFG_A_PD_WORDS;
  wire wr_pc       = reg_write && reg_addr == `RSDCFG_A_PC_WORDS;
  wire wr_preset   = reg_write && reg_addr == `RSDCFG_A_PRESET;
  wire wr_mon      = reg_write && reg_addr == `RSDCFG_A_MON_PERIOD;
  wire wr_ien      = reg_write && reg_addr == `RSDCFG_A_IRQ_ENABLE;
  wire wr_iclr     = reg_write && reg_addr == `RSDCFG_A_IRQ_CLEAR;

  wire baud_ok  = reg_wdata[31:4] == 28'h0 && reg_wdata[3:0] <= `RSDCFG_BAUD_MAX;
  wire pd_ok    = reg_wdata[31:4] == 28'h0 && reg_wdata[3:0] <= `RSDCFG_PD_MAX;
  wire pc_ok    = reg_wdata[31:7] == 25'h0 &&
                  (reg_wdata[6:0] == 7'h00 || reg_wdata[6:0] == 7'h03 ||
                   reg_wdata[6:0] == 7'h04 || reg_wdata[6:0] == `RSDCFG_PC_VAR);
  wire addr_ok  = !sw_valid && reg_wdata[31:5] == 27'h0;
  wire rejected = (wr_baud && !baud_ok) || (wr_pd && !pd_ok) ||
                  (wr_pc && !pc_ok) || (wr_addr && !addr_ok);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protocol_select_q            <= 8'h00;
      baud_rate_select_q           <= `RSDCFG_BAUD_RST;
      configured_station_address_q <= `RSDCFG_ADDR_RST;
      process_word_count_q         <= `RSDCFG_PD_RST;
      param_channel_word_count_q   <= `RSDCFG_PC_RST;
      setup_preset_select_q        <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wr_protocol) protocol_select_q <= reg_wdata[7:0];
      if (wr_baud && baud_ok) baud_rate_select_q <= reg_wdata[3:0];
      if (wr_addr && addr_ok) configured_station_address_q <= reg_wdata[4:0];
      if (wr_pd && pd_ok) process_word_count_q <= reg_wdata[3:0];
      if (wr_pc && pc_ok) param_channel_word_count_q <= reg_wdata[6:0];
      if (wr_preset) setup_preset_select_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_monitor_period_q <= 21'(MON_MS_DEFAULT);
      irq_enable_q         <= '0;
    end
    else if (clk_en)
    begin
      if (wr_mon) bus_monitor_period_q <= reg_wdata[20:0];
      if (wr_ien) irq_enable_q <= reg_wdata[`RSDCFG_IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Address latch at power-up
  // ==========================================================================
  logic       addr_latched_q;
  logic [4:0] station_addr_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_latched_q <= 1'b0;
      station_addr_q <= `RSDCFG_ADDR_RST;
    end
    else if (clk_en && !addr_latched_q && sync_full && sw_s3_q == sw_q)
    begin
      // Waits until the filtered switch has settled, then freezes.
      addr_latched_q <= 1'b1;
      station_addr_q <= sw_valid ? sw_q[4:0] : configured_station_address_q;
    end
  end

  assign station_addr = station_addr_q;

  // ==========================================================================
  // Bus enable, monitoring and transmitter control
  // ==========================================================================
  // The bus stays off until the address is latched, so no frame meets the reset address.
  wire bus_on = protocol_select_q == `RSDCFG_PROTOCOL_ON &&
                setup_preset_select_q == `RSDCFG_PRESET_BUS &&
                addr_latched_q;

  // The prescaler and the period count restart on every process-data frame for this
  // station and stay at zero while monitoring is off.
  localparam logic [20:0] MS_CYC = 21'(CYCLES_PER_MS);
  logic [20:0] ms_cnt_q;
  logic [20:0] mon_ms_q;
  wire         ms_tick = ms_cnt_q == MS_CYC - 21'h1;
  wire         for_us  = frame_valid && frame_addr == station_addr_q;
  wire         pd_seen = for_us && frame_has_pd;
  wire         mon_on  = bus_on && bus_monitor_period_q != 21'h0;
  wire         timeout = mon_on && ms_tick && mon_ms_q + 21'h1 >= bus_monitor_period_q;

  rsdcfg_state_type state_q;
  rsdcfg_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RSDCFG_IDLE:
        if (timeout)
          state_d = RSDCFG_FAULT;
        else if (bus_on && for_us)
          state_d = RSDCFG_ANSWER;
      RSDCFG_ANSWER:
        if (timeout)
          state_d = RSDCFG_FAULT;
        else if (answer_done || !bus_on)
          state_d = RSDCFG_IDLE;
      RSDCFG_FAULT:
        state_d = RSDCFG_FAULT;                    // Held until reset.
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= RSDCFG_IDLE;
      ms_cnt_q <= 21'h0;
      mon_ms_q <= 21'h0;
    end
    else if (clk_en)
    begin
      state_q  <= state_d;
      ms_cnt_q <= (ms_tick || !mon_on || pd_seen) ? 21'h0 : ms_cnt_q + 21'h1;
      if (!mon_on || pd_seen)
        mon_ms_q <= 21'h0;
      else if (ms_tick)
        mon_ms_q <= mon_ms_q + 21'h1;
    end
  end

  assign bus_enable  = bus_on && state_q != RSDCFG_FAULT;
  assign tx_enable   = state_q == RSDCFG_ANSWER;
  assign drive_fault = state_q == RSDCFG_FAULT;

  // ==========================================================================
  // Interrupts and read-back
  // ==========================================================================
  wire [`RSDCFG_IRQ_W-1:0] irq_evt = {rejected && reg_write, bus_on && for_us, timeout};

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_q <= '0;
    else if (clk_en)
      irq_status_q <= (irq_status_q & ~({`RSDCFG_IRQ_W{wr_iclr}} &
                      reg_wdata[`RSDCFG_IRQ_W-1:0])) | irq_evt;
  end

  assign irq = |(irq_status_q & irq_enable_q);

  wire [5:0] status_bits = {sw_valid, addr_latched_q, bus_on, drive_fault, tx_enable,
                            bus_enable};

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (reg_addr)
      `RSDCFG_A_PROTOCOL:    rd_mux = {24'h0, protocol_select_q};
      `RSDCFG_A_BAUD:        rd_mux = {28'h0, baud_rate_select_q};
      `RSDCFG_A_CFG_ADDR:    rd_mux = {27'h0, configured_station_address_q};
      `RSDCFG_A_PD_WORDS:    rd_mux = {28'h0, process_word_count_q};
      `RSDCFG_A_PC_WORDS:    rd_mux = {25'h0, param_channel_word_count_q};
      `RSDCFG_A_PRESET:      rd_mux = {24'h0, setup_preset_select_q};
      `RSDCFG_A_MON_PERIOD:  rd_mux = {11'h0, bus_monitor_period_q};
      `RSDCFG_A_STATUS:      rd_mux = {26'h0, status_bits};
      `RSDCFG_A_IRQ_STATUS:  rd_mux = {29'h0, irq_status_q};
      `RSDCFG_A_IRQ_ENABLE:  rd_mux = {29'h0, irq_enable_q};
      `RSDCFG_A_ACTIVE_ADDR: rd_mux = {27'h0, station_addr_q};
      default:               rd_mux = 32'h0;
    endcase
  end

  // Read data stand for the one cycle after the read strobe and read as zero otherwise.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (clk_en)
      reg_rdata <= reg_read ? rd_mux : 32'h0;
  end

endmodule // rsdcfg_top

// [verification/rsdcfg_top_assertions.sv]
// Checker for the slave configuration block, fed from its top ports.
// Assumes binding to rsdcfg_top; clk_en drops only while no read data stand.
`timescale 1ns/1ps
`include "rsdcfg_consts.svh"

module rsdcfg_checker
(
  input wire logic                         clk,
  input wire logic                         reset_n,
  input wire rsdcfg_pkg::rsdcfg_addr_type  reg_addr,
  input wire logic                         reg_read,
  input wire logic [31:0]                  reg_rdata,
  input wire logic                         frame_valid,
  input wire logic [4:0]                   frame_addr,
  input wire logic                         answer_done,
  input wire logic                         bus_enable,
  input wire logic                         tx_enable,
  input wire logic [4:0]                   station_addr,
  input wire logic                         drive_fault,
  input wire logic                         irq
);
  import rsdcfg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Assertions
  a_tx_only_addressed: assert property (
    $rose(tx_enable) |-> $past(frame_valid) && $past(frame_addr) == station_addr)
    else $error("Transmitter rose without an addressed frame.");
  a_tx_answers_frame: assert property (
    frame_valid && frame_addr == station_addr && bus_enable && !answer_done |=> tx_enable)
    else $error("Addressed frame got no transmitter enable.");
  a_tx_release: assert property (
    answer_done |=> !tx_enable)
    else $error("Transmitter held after the answer ended.");
  a_fault_sticky: assert property (
    drive_fault |=> drive_fault)
    else $error("Fault cleared without a reset.");
  a_fault_quiets_bus: assert property (
    drive_fault |-> !bus_enable && !tx_enable)
    else $error("Bus still active while faulted.");
  a_addr_frozen: assert property (
    bus_enable |=> $stable(station_addr))
    else $error("Station address changed in operation.");
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h00000000)
    else $error("Read data present without a read.");
  a_baud_range: assert property (
    $past(reg_read) && $past(reg_addr) == `RSDCFG_A_BAUD |-> reg_rdata <= 32'h0000000b)
    else $error("Baud code out of range.");
  a_pd_range: assert property (
    $past(reg_read) && $past(reg_addr) == `RSDCFG_A_PD_WORDS |-> reg_rdata <= 32'h00000008)
    else $error("Process word count out of range.");
  c_tx: cover property ($rose(tx_enable));
  c_fault: cover property ($rose(drive_fault));
  c_irq: cover property ($rose(irq));
endmodule // rsdcfg_checker

// [verification/rsdcfg_master_model.sv]
// Model of the bus master and framing side feeding telegrams to the block.
// Assumes the bench pulses send for one cycle and holds lag steady.
`timescale 1ns/1ps

module rsdcfg_master_model
(
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic [4:0] send_addr,
  input  wire logic       send_pd,
  input  wire logic [3:0] lag,
  input  wire logic       tx_enable,
  output logic            frame_valid,
  output logic [4:0]      frame_addr,
  output logic            frame_has_pd,
  output logic            answer_done
);
  logic [3:0] wait_q;
  initial
  begin
    frame_valid = 1'b0;
    frame_addr = 5'h00;
    frame_has_pd = 1'b0;
    answer_done = 1'b0;
    wait_q = 4'h0;
  end
  // Outside a frame the address lines toggle so a stale value never stands for two cycles in a row.
  always @(posedge clk)
  begin
    frame_valid <= send;
    frame_addr <= send ? send_addr : ~frame_addr;
    frame_has_pd <= send & send_pd;
    answer_done <= tx_enable && !answer_done && wait_q == lag;
    wait_q <= (tx_enable && !answer_done) ? wait_q + 4'h1 : 4'h0;
  end
endmodule // rsdcfg_master_model

// [verification/rsdcfg_bench.sv]
// Self-checking bench for the slave configuration block.
// Assumes the design, the master model and the checker are compiled first.
`timescale 1ns/1ps

module rsdcfg_bench;
  import rsdcfg_pkg::*;
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            clk_en = 1'b1;
  rsdcfg_addr_type reg_addr = 4'h0;
  rsdcfg_data_type reg_wdata = 32'h0;
  logic            reg_write = 1'b0;
  logic            reg_read = 1'b0;
  logic [31:0]     reg_rdata, rv, seed = 32'h00000062;
  logic [5:0]      addr_switch = 6'h0a;
  logic            send = 1'b0, send_pd = 1'b0;
  logic [4:0]      send_addr = 5'h00, frame_addr, station_addr;
  logic [3:0]      lag = 4'h2;
  logic            frame_valid, frame_has_pd, answer_done, bus_enable, tx_enable, drive_fault, irq;
  int              miscompares = 0, check_count = 0;

  rsdcfg_top #(.CYCLES_PER_MS(10)) dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .addr_switch(addr_switch), .frame_valid(frame_valid),
    .frame_addr(frame_addr), .frame_has_pd(frame_has_pd), .answer_done(answer_done),
    .bus_enable(bus_enable), .tx_enable(tx_enable), .station_addr(station_addr),
    .drive_fault(drive_fault), .irq(irq));
  rsdcfg_master_model far (.clk(clk), .send(send), .send_addr(send_addr), .send_pd(send_pd),
    .lag(lag), .tx_enable(tx_enable), .frame_valid(frame_valid), .frame_addr(frame_addr),
    .frame_has_pd(frame_has_pd), .answer_done(answer_done));

  initial
  begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] exp_reset(input int a);
    logic [31:0] t[7] = '{32'h0, 32'h8, 32'h0, 32'h2, 32'h4, 32'h0, 32'h64};
    return t[a];
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic frame(input logic [4:0] a, input logic pd);
    @(posedge clk);
    send <= 1'b1;
    send_addr <= a;
    send_pd <= pd;
    @(posedge clk);
    send <= 1'b0;
    #1;
  endtask
  // Waits on the transmitter enable, or on the fault flag when sel is set.
  task automatic wait_on(input bit sel, input logic v);
    for (int n = 0; n < 100 && (sel ? drive_fault : tx_enable) !== v; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk((sel ? drive_fault : tx_enable), v);
    if ((sel ? drive_fault : tx_enable) !== v)
      test_done();
  endtask
  task automatic reset_dut();
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] wa[9], wd[9], we[9], r;
    reset_dut();
    for (int a = 0; a < 7; a++)
    begin
      rd(a[3:0], rv);
      chk(rv, exp_reset(a));
    end
    rd(4'hb, rv);
    chk(rv, 32'h0000000a);
    rd(4'he, rv);
    chk(rv, 32'h0);
    $display("test reset_values done");
    r = rnd() % 12;
    wa = '{32'h2, 32'h1, 32'h1, 32'h3, 32'h3, 32'h4, 32'h4, 32'h4, 32'h4};
    wd = '{32'h5, 32'hc, r, 32'h9, 32'h8, 32'h5, 32'h7f, 32'h3, 32'h0};
    we = '{32'h0, 32'h8, r, 32'h2, 32'h8, 32'h4, 32'h7f, 32'h3, 32'h0};
    for (int i = 0; i < 9; i++)
    begin
      wr(wa[i][3:0], wd[i]);
      rd(wa[i][3:0], rv);
      chk(rv, we[i]);
    end
    clk_en <= 1'b0;
    wr(4'h1, r ^ 32'h1);
    clk_en <= 1'b1;
    rd(4'h1, rv);
    chk(rv, r);
    rd(4'h8, rv);
    chk(rv & 32'h4, 32'h4);
    chk(irq, 1'b0);
    wr(4'h9, 32'h4);
    chk(irq, 1'b1);
    wr(4'ha, 32'h4);
    chk(irq, 1'b0);
    wr(4'h9, 32'h2);
    $display("test write_checks done");
    wr(4'h0, 32'h1);
    wr(4'h5, 32'h14);
    chk(bus_enable, 1'b0);
    wr(4'h5, 32'h15);
    chk(bus_enable, 1'b1);
    chk(station_addr, 32'ha);
    r = rnd() % 32;
    frame((r == 10) ? 5'h0b : r[4:0], 1'b0);
    repeat (6) @(posedge clk);
    #1;
    chk(tx_enable, 1'b0);
    frame(5'h0a, 1'b1);
    wait_on(1'b0, 1'b1);
    chk(irq, 1'b1);
    wait_on(1'b0, 1'b0);
    wr(4'ha, 32'h2);
    chk(irq, 1'b0);
    $display("test frames done");
    addr_switch <= 6'h05;
    wr(4'h6, 32'h3);
    repeat (4)
    begin
      frame(5'h0a, 1'b1);
      repeat (15) @(posedge clk);
    end
    #1;
    chk(drive_fault, 1'b0);
    wait_on(1'b1, 1'b1);
    chk(bus_enable, 1'b0);
    rd(4'h8, rv);
    chk(rv & 32'h1, 32'h1);
    rd(4'h7, rv);
    chk(rv, 32'h3c);
    chk(station_addr, 32'ha);
    $display("test monitor done");
    addr_switch <= 6'h3f;
    lag <= 4'h9;
    reset_dut();
    chk(station_addr, 32'h0);
    wr(4'h2, 32'h11);
    rd(4'h2, rv);
    chk(rv, 32'h11);
    wr(4'h2, 32'h20);
    rd(4'h2, rv);
    chk(rv, 32'h11);
    chk(station_addr, 32'h0);
    wr(4'h0, 32'h1);
    wr(4'h5, 32'h15);
    wr(4'h6, 32'h0);
    repeat (100) @(posedge clk);
    #1;
    chk(drive_fault, 1'b0);
    frame(5'h00, 1'b0);
    wait_on(1'b0, 1'b1);
    wait_on(1'b0, 1'b0);
    $display("test soft_address done");
    test_done();
  end
endmodule // rsdcfg_bench

bind rsdcfg_top rsdcfg_checker u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
  .frame_addr(frame_addr), .answer_done(answer_done), .bus_enable(bus_enable),
  .tx_enable(tx_enable), .station_addr(station_addr), .drive_fault(drive_fault), .irq(irq));
